// *** hdl/dac_channel_volume_mute_ctrl.sv ***
// Stereo DAC channel source, soft-stepped volume, mute and auto-mute control with its FIFO.
`timescale 1ns/100ps
`default_nettype none

module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	output logic [WIDTH-1:0]      rd_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;
	logic [PW:0]      next_count;

	assign push = wr_valid && wr_ready;
	assign pop = rd_valid && rd_ready;
	assign rd_data = mem[rd_ptr];

	always_comb
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count <= '0;
			wr_ready <= 1'b1;
			rd_valid <= 1'b0;
		end
		else
		begin
			count <= next_count;
			wr_ready <= next_count != FULL_COUNT;
			rd_valid <= next_count != '0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= wr_data;
	end
endmodule : sample_fifo

module dac_channel_volume_mute_ctrl #(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [dac_ctrl_pkg::ADDR_W-1:0] address,
	input  wire logic                       read,
	input  wire logic                       write,
	input  wire logic [31:0]                writedata,
	input  wire logic [3:0]                 byteenable,
	output logic [31:0]                     readdata,
	output logic                            waitrequest,
	input  wire logic                       word_clk,
	input  wire dac_ctrl_pkg::frame_type    in_frame,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output dac_ctrl_pkg::frame_type         out_frame,
	output logic                            out_valid
);
	logic [7:0]              setup_one;
	logic [7:0]              setup_two;
	logic signed [7:0]       left_vol;
	logic signed [7:0]       right_vol;
	logic signed [7:0]       left_gain;
	logic signed [7:0]       right_gain;
	logic signed [7:0]       left_target;
	logic signed [7:0]       right_target;
	logic [2:0]              wclk_sync;
	logic                    tick;
	logic                    step_phase;
	logic                    step_now;
	logic [dac_ctrl_pkg::RUN_W-1:0] run_count;
	logic [dac_ctrl_pkg::RUN_W-1:0] run_limit;
	logic                    auto_muted;
	logic                    mute_live;
	dac_ctrl_pkg::frame_type last_frame;
	dac_ctrl_pkg::frame_type fifo_frame;
	logic                    fifo_valid;
	logic                    take;
	logic [7:0]              index;
	logic                    hit;
	logic                    wr_hit;
	dac_ctrl_pkg::step_type  step_code;
	dac_ctrl_pkg::link_type  link_code;
	logic [2:0]              amute_code;
	logic signed [15:0]      next_left;
	logic signed [15:0]      next_right;

	sample_fifo #(
		.WIDTH ($bits(dac_ctrl_pkg::frame_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.wr_data  (in_frame),
		.wr_valid (in_valid),
		.wr_ready (in_ready),
		.rd_data  (fifo_frame),
		.rd_valid (fifo_valid),
		.rd_ready (tick)
	);

	// The gain is 2^(code/12) split into a table fraction and a power-of-two shift.
	function automatic logic signed [15:0] apply_gain(input logic signed [15:0] s,
		input logic signed [7:0] g);
		logic [7:0] b;
		logic [3:0] q;
		logic signed [39:0] p;
		b = g + dac_ctrl_pkg::GAIN_BIAS;
		q = 4'(b / dac_ctrl_pkg::GAIN_DIV);
		p = 40'(s) * $signed({24'h000000, dac_ctrl_pkg::gain_frac(4'(b % dac_ctrl_pkg::GAIN_DIV))});
		p = (p <<< 4) >>> (dac_ctrl_pkg::SHIFT_TOP - 5'(q)); // R10 R11
		if (p > 40'(dac_ctrl_pkg::SAMPLE_MAX))
			return dac_ctrl_pkg::SAMPLE_MAX;
		if (p < 40'(dac_ctrl_pkg::SAMPLE_MIN))
			return dac_ctrl_pkg::SAMPLE_MIN;
		return p[15:0];
	endfunction : apply_gain
	function automatic logic signed [15:0] pick_source(input logic [1:0] sel,
		input logic signed [15:0] own, input logic signed [15:0] other);
		logic signed [16:0] sum;
		sum = 17'(own) + 17'(other);
		unique case (sel)
			dac_ctrl_pkg::SRC_NONE: return '0;
			dac_ctrl_pkg::SRC_OWN: return own;
			dac_ctrl_pkg::SRC_OTHER: return other;
			default: return sum[16:1];
		endcase
	endfunction : pick_source
	function automatic logic signed [7:0] step_toward(input logic signed [7:0] cur,
		input logic signed [7:0] tgt);
		if (cur < tgt)
			return cur + 8'sh01;
		if (cur > tgt)
			return cur - 8'sh01;
		return cur;
	endfunction : step_toward
	assign index = address[dac_ctrl_pkg::ADDR_W-1:2];
	assign hit = (read || write) && !waitrequest;
	assign wr_hit = hit && write && byteenable[0];
	assign step_code = dac_ctrl_pkg::step_type'(setup_one[dac_ctrl_pkg::STEP_LSB +: 2]);
	assign link_code = dac_ctrl_pkg::link_type'(setup_two[dac_ctrl_pkg::LINK_LSB +: 2]);
	assign amute_code = setup_two[dac_ctrl_pkg::AMUTE_LSB +: 3];
	assign take = tick && fifo_valid;
	assign mute_live = auto_muted && fifo_frame == last_frame; // R15
	// Waitrequest idles high, so every access is answered one cycle after it appears.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && waitrequest);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			readdata <= '0;
		else if (read && waitrequest)
			unique case (index)
				dac_ctrl_pkg::SETUP_ONE_IDX: readdata <= {24'h000000, setup_one};
				dac_ctrl_pkg::SETUP_TWO_IDX: readdata <= {24'h000000, setup_two};
				dac_ctrl_pkg::LEFT_VOL_IDX: readdata <= {24'h000000, left_vol};
				dac_ctrl_pkg::RIGHT_VOL_IDX: readdata <= {24'h000000, right_vol};
				dac_ctrl_pkg::STATUS_IDX: readdata <= {15'h0000, auto_muted, right_gain, left_gain};
				default: readdata <= '0;
			endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			setup_one <= dac_ctrl_pkg::SETUP_ONE_RST;
			setup_two <= dac_ctrl_pkg::SETUP_TWO_RST; // R7 R8
			left_vol <= dac_ctrl_pkg::VOL_RST;
			right_vol <= dac_ctrl_pkg::VOL_RST;
		end
		else if (wr_hit)
			unique case (index)
				dac_ctrl_pkg::SETUP_ONE_IDX: setup_one <= writedata[7:0];
				dac_ctrl_pkg::SETUP_TWO_IDX: setup_two <= writedata[7:0];
				dac_ctrl_pkg::LEFT_VOL_IDX: left_vol <= writedata[7:0];
				dac_ctrl_pkg::RIGHT_VOL_IDX: right_vol <= writedata[7:0];
				default: ;
			endcase
	end
	// The word clock is a pin, so it is synchronised before the edge is taken.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wclk_sync <= '0;
		else
			wclk_sync <= {wclk_sync[1:0], word_clk};
	end
	assign tick = wclk_sync[1] && !wclk_sync[2];

	always_comb
	begin
		left_target = left_vol;
		right_target = right_vol;
		if (link_code == dac_ctrl_pkg::LINK_LEFT_FOLLOWS)
			left_target = right_vol; // R9
		else if (link_code == dac_ctrl_pkg::LINK_RIGHT_FOLLOWS)
			right_target = left_vol; // R9
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			step_phase <= 1'b0;
		else if (tick)
			step_phase <= !step_phase;
	end
	assign step_now = tick && (step_code == dac_ctrl_pkg::STEP_ONE || step_phase); // R4

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			left_gain <= dac_ctrl_pkg::VOL_RST;
			right_gain <= dac_ctrl_pkg::VOL_RST;
		end
		else if (step_code == dac_ctrl_pkg::STEP_NONE)
		begin
			left_gain <= left_target; // R4
			right_gain <= right_target;
		end
		else if (step_now)
		begin
			left_gain <= step_toward(left_gain, left_target); // R14
			right_gain <= step_toward(right_gain, right_target); // R14
		end
	end

	assign run_limit = dac_ctrl_pkg::AMUTE_BASE << (amute_code - 3'h1); // R6
	// The run counter saturates, so long silence cannot wrap back to unmuted.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			run_count <= '0;
			auto_muted <= 1'b0;
			last_frame <= '0;
		end
		else
		begin
			if (take)
			begin
				last_frame <= fifo_frame;
				if (fifo_frame != last_frame)
					run_count <= 14'h0001; // R15
				else if (!(&run_count))
					run_count <= run_count + 1'b1;
			end
			auto_muted <= amute_code != 3'h0 && run_count > run_limit; // R6
			if (take && fifo_frame != last_frame)
				auto_muted <= 1'b0; // R15
		end
	end

	always_comb
	begin
		next_left = apply_gain(pick_source(setup_one[dac_ctrl_pkg::LEFT_SEL_LSB +: 2],
			fifo_frame.left, fifo_frame.right), left_gain); // R2
		next_right = apply_gain(pick_source(setup_one[dac_ctrl_pkg::RIGHT_SEL_LSB +: 2],
			fifo_frame.right, fifo_frame.left), right_gain); // R1
		if (setup_two[dac_ctrl_pkg::LEFT_MUTE_BIT] || mute_live ||
			!setup_one[dac_ctrl_pkg::LEFT_PWR_BIT])
			next_left = '0; // R3 R6 R7
		if (setup_two[dac_ctrl_pkg::RIGHT_MUTE_BIT] || mute_live)
			next_right = '0; // R8
		if (!setup_one[dac_ctrl_pkg::RIGHT_PWR_BIT])
			next_right = setup_two[dac_ctrl_pkg::INVERT_BIT] ? ~next_left : '0; // R3 R5
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_frame <= '0;
			out_valid <= 1'b0;
		end
		else
		begin
			out_valid <= take;
			if (take)
				out_frame <= '{left: next_left, right: next_right};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_left_mute_zero: assert property (out_valid && $past(setup_two[3]) |-> // R7
		out_frame.left == '0) else $error("Muted left channel produced a nonzero sample.");
	chk_right_mute_zero: assert property (out_valid && $past(setup_two[2]) // R8
		&& $past(setup_one[6]) |-> out_frame.right == '0)
		else $error("Muted right channel produced a nonzero sample.");
	chk_left_power_down: assert property (out_valid && !$past(setup_one[7]) |-> // R3
		out_frame.left == '0) else $error("Powered-down left channel produced a nonzero sample.");
	chk_right_mod_invert: assert property (out_valid && !$past(setup_one[6]) |-> // R5
		out_frame.right == ($past(setup_two[7]) ? ~out_frame.left : 16'sh0000))
		else $error("Powered-down right modulator output is wrong.");
	chk_step_size_one: assert property (step_code != dac_ctrl_pkg::STEP_NONE ##1 // R14
		step_code != dac_ctrl_pkg::STEP_NONE |->
		left_gain - $past(left_gain) inside {8'sh00, 8'sh01, -8'sh01})
		else $error("Soft-step moved the gain by more than one code.");
	chk_step_immediate: assert property (step_code == dac_ctrl_pkg::STEP_NONE |=> // R4
		left_gain == $past(left_target) && right_gain == $past(right_target))
		else $error("Disabled soft-step did not apply the target at once.");
	chk_step_pace: assert property (!step_now && step_code != dac_ctrl_pkg::STEP_NONE |=> // R4
		$stable(left_gain) && $stable(right_gain))
		else $error("Gain moved outside a step instant.");
	chk_link_left: assert property (link_code == dac_ctrl_pkg::LINK_LEFT_FOLLOWS && // R9
		step_code == dac_ctrl_pkg::STEP_NONE |=> left_gain == $past(right_vol))
		else $error("Left channel does not follow the right volume.");
	chk_automute_off: assert property (amute_code == 3'h0 |=> !auto_muted) // R6
		else $error("Auto-mute active while disabled.");
	chk_automute_exit: assert property (take && fifo_frame != last_frame |=> // R15
		!auto_muted && run_count == 14'h0001) else $error("Changed sample did not end auto-mute.");
	cov_automute_hit: cover property (!auto_muted ##1 auto_muted);
	cov_soft_step: cover property (step_now && left_gain != left_target);
	cov_fifo_full: cover property (!in_ready);
	cov_linked: cover property (link_code == dac_ctrl_pkg::LINK_RIGHT_FOLLOWS && out_valid);
endmodule : dac_channel_volume_mute_ctrl

`default_nettype wire

// *** hdl/dac_ctrl_pkg.sv ***
// Shared constants, types and gain helpers for the DAC channel control block.
// Notes on behaviour
// R1: The right channel input is 00 nothing, 01 right samples, 10 left samples, 11 mono mix.
// R2: The left channel input is 00 nothing, 01 left samples, 10 right samples, 11 mono mix.
// R3: Each channel has a power bit; 0 powers it down and 1 powers it up.
// R4: Soft-step code 00 steps every word clock, 01 every two word clocks, 10 applies at once.
// R5: A powered-down right channel outputs zero, or the inverted left output when enabled.
// R6: Auto-mute code 000 is off; 001..111 mute after more than 100..6400 unchanged samples.
// R7: The left channel is muted while its mute bit is 1, which is its reset value.
// R8: The right channel is muted while its mute bit is 1, its reset value, except when powered down with invert set, where it outputs the inverted left output.
// R9: Link code 00 is independent, 01 left follows right volume, 10 right follows left.
// R10: The left volume is 8-bit two's complement in half-decibel steps, 0 dB at zero.
// R11: The right volume uses the same coding, from -63.5 dB up to +24 dB.
// R12: Software never writes volume codes above +24 dB or the code 1000 0000.
// R13: Software never writes code 11 into the soft-step or link fields.
// R14: Each soft-step moves the applied gain by one code toward the target.
// R15: Auto-mute ends as soon as a sample differs, and the run count restarts.
package dac_ctrl_pkg;
	localparam int unsigned ADDR_W = 10;
	localparam logic [7:0] SETUP_ONE_IDX = 8'h3F;
	localparam logic [7:0] SETUP_TWO_IDX = 8'h40;
	localparam logic [7:0] LEFT_VOL_IDX = 8'h41;
	localparam logic [7:0] RIGHT_VOL_IDX = 8'h42;
	localparam logic [7:0] STATUS_IDX = 8'h48;
	localparam logic [7:0] SETUP_ONE_RST = 8'h14;
	localparam logic [7:0] SETUP_TWO_RST = 8'h0C;
	localparam logic [7:0] VOL_RST = 8'h00;
	localparam int LEFT_PWR_BIT = 7;
	localparam int RIGHT_PWR_BIT = 6;
	localparam int LEFT_SEL_LSB = 4;
	localparam int RIGHT_SEL_LSB = 2;
	localparam int STEP_LSB = 0;
	localparam int INVERT_BIT = 7;
	localparam int AMUTE_LSB = 4;
	localparam int LEFT_MUTE_BIT = 3;
	localparam int RIGHT_MUTE_BIT = 2;
	localparam int LINK_LSB = 0;
	localparam int RUN_W = 14;
	localparam logic [RUN_W-1:0] AMUTE_BASE = 14'h0064;
	localparam logic [7:0] GAIN_BIAS = 8'h84;
	localparam logic [7:0] GAIN_DIV = 8'h0C;
	localparam logic [4:0] SHIFT_TOP = 5'h1E;
	localparam logic signed [15:0] SAMPLE_MAX = 16'sh7FFF;
	localparam logic signed [15:0] SAMPLE_MIN = -16'sh8000;

	typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_OWN = 2'h1, SRC_OTHER = 2'h2,
		SRC_MONO = 2'h3} source_type;
	typedef enum logic [1:0] {STEP_ONE = 2'h0, STEP_TWO = 2'h1, STEP_NONE = 2'h2} step_type;
	typedef enum logic [1:0] {LINK_NONE = 2'h0, LINK_LEFT_FOLLOWS = 2'h1,
		LINK_RIGHT_FOLLOWS = 2'h2} link_type;

	typedef struct packed {
		logic signed [15:0] left;
		logic signed [15:0] right;
	} frame_type;

	// Fractional part of 2^(k/12) in Q1.15, one entry per half-decibel within 6 dB.
	function automatic logic [15:0] gain_frac(input logic [3:0] k);
		logic [15:0] f;
		f = 16'h8000;
		case (k)
			4'h1: f = 16'h879C;
			4'h2: f = 16'h8FAD;
			4'h3: f = 16'h9838;
			4'h4: f = 16'hA145;
			4'h5: f = 16'hAADC;
			4'h6: f = 16'hB505;
			4'h7: f = 16'hBFC9;
			4'h8: f = 16'hCB30;
			4'h9: f = 16'hD745;
			4'hA: f = 16'hE412;
			4'hB: f = 16'hF1A2;
			default: f = 16'h8000;
		endcase
		return f;
	endfunction : gain_frac
endpackage : dac_ctrl_pkg

// *** bench/audio_host_model.sv ***
// Behavioural audio host that offers sample frames and makes word clock ticks.
`timescale 1ns/100ps
`default_nettype none
module audio_host_model (
	input  wire logic                  clk,
	output var logic                   word_clk,
	output var dac_ctrl_pkg::frame_type in_frame,
	output var logic                   in_valid,
	input  wire logic                  in_ready
);
	initial
	begin
		word_clk = 1'b0;
		in_frame = '0;
		in_valid = 1'b0;
	end
	// The offer stands until ready is seen at a rising edge; the data then turns to garbage.
	task automatic send(input dac_ctrl_pkg::frame_type f);
		@(posedge clk);
		in_frame <= f;
		in_valid <= 1'b1;
		do
			@(posedge clk);
		while (in_ready !== 1'b1);
		in_valid <= 1'b0;
		in_frame <= ~f;
	endtask : send
	// One word clock period, long enough for the synchroniser and the output pulse.
	task automatic tick();
		@(posedge clk);
		word_clk <= 1'b1;
		repeat (4) @(posedge clk);
		word_clk <= 1'b0;
		repeat (5) @(posedge clk);
	endtask : tick
endmodule : audio_host_model
`default_nettype wire

// *** bench/dac_channel_volume_mute_ctrl_tb.sv ***
// Self-checking bench for the DAC channel volume, mute and auto-mute block.
`timescale 1ns/100ps
`default_nettype none
module dac_channel_volume_mute_ctrl_tb;
	logic                    clk, rst, read, write, waitrequest, word_clk;
	logic                    in_valid, in_ready, out_valid;
	logic [9:0]              address;
	logic [31:0]             writedata, readdata;
	logic [3:0]              byteenable;
	dac_ctrl_pkg::frame_type in_frame, out_frame;
	logic [7:0]              s1, s2;
	logic [31:0]             got[$];
	int                      fail_count, checks_done;

	dac_channel_volume_mute_ctrl #(.FIFO_DEPTH(32)) dac_channel_volume_mute_ctrl_i (
		.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .word_clk(word_clk), .in_frame(in_frame),
		.in_valid(in_valid), .in_ready(in_ready), .out_frame(out_frame), .out_valid(out_valid));
	audio_host_model audio_host_model_i (.clk(clk), .word_clk(word_clk), .in_frame(in_frame),
		.in_valid(in_valid), .in_ready(in_ready));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
		if (out_valid === 1'b1)
			got.push_back(out_frame);

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= {24'h000000, d};
		byteenable <= be;
		read <= ~wr;
		write <= wr;
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, 4'hF, q);
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [31:0] q);
		bus(1'b0, idx, 8'h00, 4'hF, q);
	endtask : rd
	// Step and link fields are never given the reserved code 11.
	task automatic cfg(input logic [7:0] a, input logic [7:0] b);
		wr(dac_ctrl_pkg::SETUP_ONE_IDX, a);
		wr(dac_ctrl_pkg::SETUP_TWO_IDX, b);
		s1 = a;
		s2 = b;
	endtask : cfg
	function automatic logic [15:0] pick(input logic [1:0] c, input logic [15:0] o,
		input logic [15:0] x, input logic [15:0] m);
		case (c)
			2'h0: return 16'h0000;
			2'h1: return o;
			2'h2: return x;
			default: return m;
		endcase
	endfunction : pick
	// Expected output at unity gain; even sums keep the mono mix free of rounding.
	function automatic logic [31:0] model(input logic [31:0] f, input logic am);
		logic [16:0] sum;
		logic [15:0] lo, ro;
		sum = {f[31], f[31:16]} + {f[15], f[15:0]};
		lo = pick(s1[5:4], f[31:16], f[15:0], sum[16:1]);
		ro = pick(s1[3:2], f[15:0], f[31:16], sum[16:1]);
		if (!s1[7] || s2[3] || am)
			lo = 16'h0000;
		if (!s1[6])
			ro = s2[7] ? ~lo : 16'h0000;
		else if (s2[2] || am)
			ro = 16'h0000;
		return {lo, ro};
	endfunction : model
	function automatic logic [31:0] rf();
		logic [31:0] f;
		f = $urandom;
		f[0] = f[16];
		return f;
	endfunction : rf
	task automatic xfer(input logic [31:0] f, input logic am);
		logic [31:0] e;
		e = model(f, am);
		audio_host_model_i.send(f);
		audio_host_model_i.tick();
		chk("out count", 32'h1, 32'(got.size()));
		if (got.size() == 1)
			chk("out_frame", e, got[0]);
		got.delete();
	endtask : xfer

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("BAD watchdog expected finish seen hang");
		test_done();
	end
	initial
	begin
		logic [31:0] q;
		logic [31:0] f[$];
		logic [7:0] v;
		int i;
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		byteenable = 4'hF;
		fail_count = 0;
		checks_done = 0;
		void'($urandom(32'h850B));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(dac_ctrl_pkg::SETUP_ONE_IDX, q);
		chk("setup_one", 32'h14, q);
		rd(dac_ctrl_pkg::SETUP_TWO_IDX, q);
		chk("setup_two", 32'h0C, q);
		rd(dac_ctrl_pkg::LEFT_VOL_IDX, q);
		chk("left_vol", 32'h00, q);
		rd(dac_ctrl_pkg::RIGHT_VOL_IDX, q);
		chk("right_vol", 32'h00, q);
		rd(8'h10, q);
		chk("unmapped", 32'h00, q);
		bus(1'b1, dac_ctrl_pkg::SETUP_TWO_IDX, 8'h00, 4'hE, q);
		rd(dac_ctrl_pkg::SETUP_TWO_IDX, q);
		chk("byteenable", 32'h0C, q);
		for (i = 0; i < 4; i++)
		begin
			v = (i < 2) ? 8'($urandom) : 8'($urandom_range(175) - 127);
			if (i < 2)
				v[1:0] = 2'($urandom_range(2));
			wr(8'h3F + 8'(i), v);
			rd(8'h3F + 8'(i), q);
			chk("readback", {24'h0, v}, q);
		end
		$display("test registers done");
		cfg(8'hD6, 8'h00);
		wr(dac_ctrl_pkg::LEFT_VOL_IDX, 8'h00);
		wr(dac_ctrl_pkg::RIGHT_VOL_IDX, 8'h00);
		for (i = 0; i < 32; i++)
		begin
			if (i < 16)
				cfg({2'b11, 4'(i), 2'b10}, 8'h00);
			else
				cfg({2'(i), 4'b0101, 2'b10}, {i[2], 3'b000, i[3], i[3] ^ i[2], 2'b00});
			xfer(rf(), 1'b0);
		end
		$display("test sources done");
		cfg(8'hF6, 8'h00);
		for (i = 0; i < 32; i++)
		begin
			f.push_back(rf());
			audio_host_model_i.send(f[i]);
		end
		@(negedge clk);
		chk("in_ready full", 32'h0, {31'h0, in_ready});
		for (i = 0; i < 32; i++)
			audio_host_model_i.tick();
		chk("drain count", 32'd32, 32'(got.size()));
		for (i = 0; i < 32 && i < got.size(); i++)
			chk("drain", model(f[i], 1'b0), got[i]);
		got.delete();
		chk("in_ready empty", 32'h1, {31'h0, in_ready});
		$display("test fifo done");
		cfg(8'hD4, 8'h00);
		wr(dac_ctrl_pkg::LEFT_VOL_IDX, 8'h05);
		repeat (3) audio_host_model_i.tick();
		rd(dac_ctrl_pkg::STATUS_IDX, q);
		chk("step every tick", 32'h03, {24'h0, q[7:0]});
		repeat (4) audio_host_model_i.tick();
		rd(dac_ctrl_pkg::STATUS_IDX, q);
		chk("step target", 32'h05, {24'h0, q[7:0]});
		cfg(8'hD6, 8'h00);
		wr(dac_ctrl_pkg::LEFT_VOL_IDX, 8'hF6);
		rd(dac_ctrl_pkg::STATUS_IDX, q);
		chk("step off", 32'hF6, {24'h0, q[7:0]});
		cfg(8'hD5, 8'h00);
		wr(dac_ctrl_pkg::LEFT_VOL_IDX, 8'h00);
		repeat (4) audio_host_model_i.tick();
		rd(dac_ctrl_pkg::STATUS_IDX, q);
		chk("step every two", 32'hF8, {24'h0, q[7:0]});
		cfg(8'hD6, 8'h01);
		wr(dac_ctrl_pkg::RIGHT_VOL_IDX, 8'h30);
		rd(dac_ctrl_pkg::STATUS_IDX, q);
		chk("left follows", 32'h3030, {16'h0, q[15:0]});
		cfg(8'hD6, 8'h02);
		wr(dac_ctrl_pkg::LEFT_VOL_IDX, 8'h81);
		rd(dac_ctrl_pkg::STATUS_IDX, q);
		chk("right follows", 32'h8181, {16'h0, q[15:0]});
		cfg(8'hD6, 8'h00);
		wr(dac_ctrl_pkg::LEFT_VOL_IDX, 8'h00);
		wr(dac_ctrl_pkg::RIGHT_VOL_IDX, 8'h00);
		$display("test volume done");
		// Frame 101 has exactly 100 equal frames before it, so only frame 102 on is muted.
		cfg(8'hD6, 8'h10);
		for (i = 1; i <= 104; i++)
			xfer(32'h01000100, i >= 102);
		xfer(32'h02000200, 1'b0);
		$display("test auto-mute done");
		test_done();
	end
endmodule : dac_channel_volume_mute_ctrl_tb
`default_nettype wire
